// ### pcts_regs.vh
// register map and timing constants of the periodic transmit scheduler
// assumes a 50 MHz aclk and 32-bit AXI4-Lite software access
`ifndef PCTS_REGS_VH
`define PCTS_REGS_VH
`define PCTS_NUM_ENTRIES 20
`define PCTS_CLK_HZ 50000000
`define PCTS_TICK_MS 10
`define PCTS_TICK_CYCLES (`PCTS_CLK_HZ / 1000 * `PCTS_TICK_MS)
// per entry: 6 words at base 0x100 + 0x20*index
`define PCTS_ENT_BASE 12'h100
`define PCTS_ENT_STRIDE_LOG2 5
`define PCTS_W_CTRL 3'h0
`define PCTS_W_PERIOD 3'h1
`define PCTS_W_DELAY 3'h2
`define PCTS_W_IDENT 3'h3
`define PCTS_W_DATA_LO 3'h4
`define PCTS_W_DATA_HI 3'h5
// ctrl fields
`define PCTS_CTRL_PRESENT 0
`define PCTS_CTRL_LONG 1
`define PCTS_CTRL_ROUTE_LSB 4
`define PCTS_CTRL_LEN_LSB 8
// global registers
`define PCTS_REG_START 12'h000
`define PCTS_REG_STATUS 12'h004
`define PCTS_REG_TIME_LOAD 12'h008
`define PCTS_REG_TIME_ADJ 12'h00C
`define PCTS_REG_RTC 12'h010
`define PCTS_ADJ_LIMIT 32'h0001FA40
`define PCTS_RESP_OKAY 2'h0
`define PCTS_RESP_SLVERR 2'h2
`endif

// ### pcts_scheduler.v
// periodic transmit scheduler: twenty entries, 10 ms tick, rtc setup
// assumes a CAN controller that takes one frame per tx_valid/tx_ready
//
// Register access over AXI4-Lite and the register addresses were chosen for this implementation.
`include "pcts_regs.vh"
`timescale 1ns/1ns
`default_nettype none
module pcts_scheduler #(
   parameter integer TICK_CYCLES = `PCTS_TICK_CYCLES
) (
   // clock and reset
   input wire aclk,
   input wire aresetn,
   // axi4-lite write
   input wire [11:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // axi4-lite read
   input wire [11:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // frame to the CAN controller
   output reg tx_valid,
   input wire tx_ready,
   output reg long_identifier_flag,
   output reg [28:0] frame_identifier,
   output reg [3:0] tx_length,
   output reg [63:0] payload_bytes,
   output reg copy_to_logger,
   output reg copy_to_host,
   // real-time clock seconds
   output reg [31:0] rtc_seconds_r
);
   localparam N = `PCTS_NUM_ENTRIES;
   localparam [19:0] TICK_MAX = TICK_CYCLES[19:0] - 20'h00001;
   localparam [2:0] S_IDLE = 3'h1;
   localparam [2:0] S_SEND = 3'h2;
   localparam [2:0] S_WAIT = 3'h4;
   ////////////////////////////////////////////////////////////////////
   // configuration storage
   reg [31:0] ctrl_r [0:N-1];
   reg [31:0] period_r [0:N-1];
   reg [31:0] delay_r [0:N-1];
   reg [31:0] ident_r [0:N-1];
   reg [31:0] dlo_r [0:N-1];
   reg [31:0] dhi_r [0:N-1];
   reg run_r;
   reg [31:0] time_load_r;
   reg [31:0] adj_r;
   reg [31:0] rtc_sub_r;

   ////////////////////////////////////////////////////////////////////
   // axi4-lite slave: write taken when both address and data present
   reg aw_hold_r, w_hold_r;
   reg [11:0] awaddr_r;
   reg [31:0] wdata_r;
   reg [3:0] wstrb_r;
   assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
   assign s_axi_wready = !w_hold_r && !s_axi_bvalid;
   wire aw_now = aw_hold_r || s_axi_awvalid;
   wire w_now = w_hold_r || s_axi_wvalid;
   wire do_wr = aw_now && w_now && !s_axi_bvalid;
   wire [11:0] wa = aw_hold_r ? awaddr_r : s_axi_awaddr;
   wire [31:0] wd = w_hold_r ? wdata_r : s_axi_wdata;
   wire [3:0] ws = w_hold_r ? wstrb_r : s_axi_wstrb;
   wire [31:0] wmask = {{8{ws[3]}}, {8{ws[2]}}, {8{ws[1]}}, {8{ws[0]}}};
   wire [31:0] wdm = wd & wmask;
   wire wa_ent = wa >= `PCTS_ENT_BASE;
   wire [6:0] wa_off = wa[11:5] - 7'h08;
   wire [2:0] w_word = wa[4:2];
   wire w_ent_ok = wa_ent && wa_off < N && w_word <= `PCTS_W_DATA_HI;
   wire w_glob_ok = !wa_ent && wa[11:5] == 7'h00 && wa[4:2] <= 3'h3;
   wire w_ok = w_ent_ok || w_glob_ok;

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_r <= 1'b0;
         w_hold_r <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `PCTS_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready && !do_wr) begin
            aw_hold_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready && !do_wr) begin
            w_hold_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
         if (do_wr) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= w_ok ? `PCTS_RESP_OKAY : `PCTS_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // global register writes
   wire wr_start = do_wr && w_glob_ok && wa[3:2] == 2'h0;
   always @(posedge aclk) begin
      if (!aresetn) begin
         run_r <= 1'b0;
         time_load_r <= 32'h00000000;
         adj_r <= 32'h00000000;
      end else if (do_wr && w_glob_ok) begin
         case (wa)
            `PCTS_REG_START: run_r <= wd[0];
            `PCTS_REG_TIME_LOAD: time_load_r <= (time_load_r & ~wmask) | wdm;
            `PCTS_REG_TIME_ADJ: adj_r <= (adj_r & ~wmask) | wdm;
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // real-time clock: load a nonzero time_load_r on start, adjust on write within the limit, count seconds
   wire [31:0] adj_mag = adj_r[31] ? (~adj_r + 32'h00000001) : adj_r;
   wire adj_ok = adj_mag <= `PCTS_ADJ_LIMIT;
   wire wr_adj = do_wr && w_glob_ok && wa == `PCTS_REG_TIME_ADJ;
   wire load_now = wr_start && wd[0] && !run_r;
   reg adj_pend_r;
   always @(posedge aclk) begin
      if (!aresetn) begin
         rtc_seconds_r <= 32'h00000000;
         rtc_sub_r <= 32'h00000000;
         adj_pend_r <= 1'b0;
      end else begin
         if (wr_adj)
            adj_pend_r <= 1'b1;
         if (load_now && time_load_r != 32'h00000000) begin
            rtc_seconds_r <= time_load_r;
            rtc_sub_r <= 32'h00000000;
         end else if (adj_pend_r && !wr_adj) begin
            adj_pend_r <= 1'b0;
            if (adj_ok)
               rtc_seconds_r <= rtc_seconds_r + adj_r;
         end else if (rtc_sub_r == `PCTS_CLK_HZ - 1) begin
            rtc_sub_r <= 32'h00000000;
            rtc_seconds_r <= rtc_seconds_r + 32'h00000001;
         end else begin
            rtc_sub_r <= rtc_sub_r + 32'h00000001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // 10 ms tick
   reg [19:0] tick_cnt_r;
   reg tick_r;
   always @(posedge aclk) begin
      if (!aresetn || !run_r) begin
         tick_cnt_r <= 20'h00000;
         tick_r <= 1'b0;
      end else if (tick_cnt_r == TICK_MAX) begin
         tick_cnt_r <= 20'h00000;
         tick_r <= 1'b1;
      end else begin
         tick_cnt_r <= tick_cnt_r + 20'h00001;
         tick_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // per entry counters and pending flags
   reg [N-1:0] pend_r;
   reg [4:0] pick;
   reg [2:0] state_r;
   wire clr_go = state_r == S_IDLE && |pend_r;
   genvar g;
   generate
      for (g = 0; g < N; g = g + 1) begin : ent
         reg [31:0] dcnt_r, pcnt_r;
         reg started_r, done_r;
         wire [31:0] dticks = delay_r[g] / `PCTS_TICK_MS;
         wire [31:0] pticks = period_r[g] / `PCTS_TICK_MS;
         wire wr_me = do_wr && w_ent_ok && wa_off == g;
         always @(posedge aclk) begin
            if (!aresetn) begin
               ctrl_r[g] <= 32'h00000000;
               period_r[g] <= 32'h00000000;
               delay_r[g] <= 32'h00000000;
               ident_r[g] <= 32'h00000000;
               dlo_r[g] <= 32'h00000000;
               dhi_r[g] <= 32'h00000000;
            end else if (wr_me) begin
               case (w_word)
                  `PCTS_W_CTRL: ctrl_r[g] <= (ctrl_r[g] & ~wmask) | wdm;
                  `PCTS_W_PERIOD: period_r[g] <= (period_r[g] & ~wmask) | wdm;
                  `PCTS_W_DELAY: delay_r[g] <= (delay_r[g] & ~wmask) | wdm;
                  `PCTS_W_IDENT: ident_r[g] <= (ident_r[g] & ~wmask) | wdm;
                  `PCTS_W_DATA_LO: dlo_r[g] <= (dlo_r[g] & ~wmask) | wdm;
                  `PCTS_W_DATA_HI: dhi_r[g] <= (dhi_r[g] & ~wmask) | wdm;
                  default: ;
               endcase
            end
         end
         wire present = ctrl_r[g][`PCTS_CTRL_PRESENT];
         wire due_delay = !started_r && dcnt_r <= 32'h00000001;
         wire due_period = started_r && pcnt_r <= 32'h00000001;
         always @(posedge aclk) begin
            if (!aresetn || !run_r) begin
               dcnt_r <= dticks;
               pcnt_r <= 32'h00000000;
               started_r <= 1'b0;
               done_r <= 1'b0;
               pend_r[g] <= 1'b0;
            end else begin
               if (clr_go && pick == g)
                  pend_r[g] <= 1'b0;
               if (tick_r && present && !done_r) begin
                  if (!started_r) begin
                     if (due_delay) begin
                        started_r <= 1'b1;
                        pend_r[g] <= 1'b1;
                        pcnt_r <= pticks;
                        if (pticks == 32'h00000000)
                           done_r <= 1'b1;
                     end else begin
                        dcnt_r <= dcnt_r - 32'h00000001;
                     end
                  end else if (due_period) begin
                     pend_r[g] <= 1'b1;
                     pcnt_r <= pticks;
                  end else begin
                     pcnt_r <= pcnt_r - 32'h00000001;
                  end
               end
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////
   // lowest index pending entry goes first
   integer i;
   always @* begin
      pick = 5'h00;
      for (i = N - 1; i >= 0; i = i - 1)
         if (pend_r[i])
            pick = i[4:0];
   end

   ////////////////////////////////////////////////////////////////////
   // frame sender
   always @(posedge aclk) begin
      if (!aresetn) begin
         state_r <= S_IDLE;
         tx_valid <= 1'b0;
         long_identifier_flag <= 1'b0;
         frame_identifier <= 29'h00000000;
         tx_length <= 4'h0;
         payload_bytes <= 64'h0000000000000000;
         copy_to_logger <= 1'b0;
         copy_to_host <= 1'b0;
      end else begin
         case (state_r)
            S_IDLE: begin
               if (clr_go) begin
                  long_identifier_flag <= ctrl_r[pick][`PCTS_CTRL_LONG];
                  frame_identifier <= ctrl_r[pick][`PCTS_CTRL_LONG] ?
                     ident_r[pick][28:0] :
                     {18'h00000, ident_r[pick][10:0]};
                  tx_length <= (ctrl_r[pick][11:8] > 4'h8) ? 4'h8 :
                     ctrl_r[pick][11:8];
                  payload_bytes <= {dhi_r[pick], dlo_r[pick]};
                  copy_to_logger <= ctrl_r[pick][`PCTS_CTRL_ROUTE_LSB];
                  copy_to_host <= ctrl_r[pick][`PCTS_CTRL_ROUTE_LSB+1];
                  tx_valid <= 1'b1;
                  state_r <= S_SEND;
               end
            end
            S_SEND: begin
               if (tx_ready) begin
                  tx_valid <= 1'b0;
                  state_r <= S_WAIT;
               end
            end
            S_WAIT: state_r <= S_IDLE;
            default: state_r <= S_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // axi4-lite read
   assign s_axi_arready = !s_axi_rvalid;
   wire ra_ent = s_axi_araddr >= `PCTS_ENT_BASE;
   wire [6:0] ra_off = s_axi_araddr[11:5] - 7'h08;
   wire [4:0] r_idx = ra_off[4:0];
   reg [31:0] rd;
   reg rok;
   always @* begin
      rd = 32'h00000000;
      rok = 1'b1;
      if (ra_ent) begin
         if (ra_off < N) begin
            case (s_axi_araddr[4:2])
               `PCTS_W_CTRL: rd = ctrl_r[r_idx];
               `PCTS_W_PERIOD: rd = period_r[r_idx];
               `PCTS_W_DELAY: rd = delay_r[r_idx];
               `PCTS_W_IDENT: rd = ident_r[r_idx];
               `PCTS_W_DATA_LO: rd = dlo_r[r_idx];
               `PCTS_W_DATA_HI: rd = dhi_r[r_idx];
               default: rok = 1'b0;
            endcase
         end else begin
            rok = 1'b0;
         end
      end else begin
         case (s_axi_araddr)
            `PCTS_REG_START: rd = {31'h00000000, run_r};
            `PCTS_REG_STATUS: rd = {12'h000, pend_r};
            `PCTS_REG_TIME_LOAD: rd = time_load_r;
            `PCTS_REG_TIME_ADJ: rd = adj_r;
            `PCTS_REG_RTC: rd = rtc_seconds_r;
            default: rok = 1'b0;
         endcase
      end
   end
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `PCTS_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd;
         s_axi_rresp <= rok ? `PCTS_RESP_OKAY : `PCTS_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule // pcts_scheduler
`default_nettype wire

// ### pcts_scheduler_chk_sva.sv
// port checker for the periodic transmit scheduler
// assumes one aclk domain; bound onto every pcts_scheduler
`timescale 1ns/1ns
`default_nettype none
module pcts_scheduler_chk (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // register bus
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // frame side
   input wire logic tx_valid,
   input wire logic tx_ready,
   input wire logic long_identifier_flag,
   input wire logic [28:0] frame_identifier,
   input wire logic [3:0] tx_length,
   input wire logic [63:0] payload_bytes,
   input wire logic [31:0] rtc_seconds_r
);
default clocking @(posedge aclk); endclocking
default disable iff (!aresetn);
a_tx_hold: assert property (
   tx_valid && !tx_ready |=> tx_valid && $stable(payload_bytes)
   && $stable(frame_identifier) && $stable(tx_length))
   else $error("frame changed before it was taken");
a_tx_gap: assert property (
   tx_valid && tx_ready |=> !tx_valid [*2])
   else $error("next frame offered too soon");
a_std_id: assert property (
   tx_valid && !long_identifier_flag |-> frame_identifier[28:11] == 18'h00000)
   else $error("standard frame with upper identifier bits");
a_len_max: assert property (
   tx_valid |-> tx_length <= 4'h8)
   else $error("frame length above eight");
a_reset_out: assert property (disable iff (1'b0)
   !aresetn |=> !tx_valid && !s_axi_bvalid && !s_axi_rvalid
   && rtc_seconds_r == 32'h00000000)
   else $error("outputs not cleared by reset");
a_b_hold: assert property (
   s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
   else $error("write response dropped");
a_r_hold: assert property (
   s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
   else $error("read data dropped");
a_wr_answer: assert property (
   s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
   |=> s_axi_bvalid)
   else $error("write response late");
a_rd_answer: assert property (
   s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
   else $error("read data late");
a_b_refuse: assert property (
   s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
   else $error("write taken while response pending");
c_slow_frame: cover property (tx_valid && !tx_ready ##1 tx_valid && tx_ready);
c_long_frame: cover property (tx_valid && tx_ready && long_identifier_flag);
c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule // pcts_scheduler_chk
bind pcts_scheduler pcts_scheduler_chk chk_u (.*);
`default_nettype wire

// ### pcts_can_model.sv
// far-side model: a CAN controller taking one frame per handshake
// assumes tx_valid stays up until taken; stall delays the answer
`timescale 1ns/1ns
`default_nettype none
module pcts_can_model (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // frame handshake
   input wire logic tx_valid,
   input wire logic stall,
   output var logic tx_ready
);
always @(posedge aclk) begin
   if (!aresetn) begin
      tx_ready <= 1'b0;
   end else begin
      // one-cycle accept pulse, held back while the bus is busy
      tx_ready <= tx_valid && !tx_ready && !stall;
   end
end
endmodule // pcts_can_model
`default_nettype wire

// ### tb_top.sv
// self-checking bench for the periodic transmit scheduler
// assumes one aclk domain; the tick is cut to TK cycles for a short run
`timescale 1ns/1ns
`default_nettype none
`include "pcts_regs.vh"
module tb_top;
localparam int TK = 50;
logic aclk = 1'b0, aresetn = 1'b0, stall = 1'b0;
logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
logic [31:0] s_axi_wdata = 32'h00000000;
logic [3:0] s_axi_wstrb = 4'hF;
wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
wire [1:0] s_axi_bresp, s_axi_rresp;
wire [31:0] s_axi_rdata, rtc_seconds_r;
wire tx_valid, tx_ready, long_identifier_flag, copy_to_logger, copy_to_host;
wire [28:0] frame_identifier;
wire [3:0] tx_length;
wire [63:0] payload_bytes;
int fail_count = 0, comparisons = 0, cyc = 0, t0 = 0, fe;
int eq[$], tq[$];
logic [1:0] bq[$];
logic [33:0] rq[$];
logic [31:0] ctl [20], idv [20], lo [20], hi [20];
logic [15:0] rs = 16'h0060, ss = 16'h0060;
int xe[5] = '{0, 19, 3, 1, 0};
int xt[5] = '{1, 1, 2, 3, 5};

pcts_scheduler #(.TICK_CYCLES(TK)) dut_u (.*);
pcts_can_model can_u (.*);
always #10 aclk = ~aclk;

////////////////////////////////////////////////////////////////////////////
function automatic logic [15:0] lfsr(input logic [15:0] x);
   return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
endfunction
function automatic logic [31:0] rnd();
   logic [15:0] a;
   a = lfsr(rs);
   rs = lfsr(a);
   return {a, rs};
endfunction
always @(posedge aclk) begin
   cyc <= cyc + 1;
   ss <= lfsr(ss);
   stall <= ss[0] & ss[3];
end
task automatic end_of_test();
   $display("comparisons %0d fail_count %0d", comparisons, fail_count);
   if (fail_count == 0 && comparisons > 0)
      $display("No errors found");
   else
      $display("Errors were found");
   $finish;
endtask
task automatic hang();
   fail_count++;
   end_of_test();
endtask
task automatic chk(input string nm, input logic [63:0] seen, exp);
   comparisons++;
   if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
   end
endtask

////////////////////////////////////////////////////////////////////////////
// k selects the awaited flag: 0 arready, 1 bvalid, 2 rvalid
task automatic wt(input int k);
   logic t;
   int n;
   t = 1'b0;
   for (n = 0; !t; n++) begin
      if (n > 99) hang();
      @(negedge aclk);
      t = (k == 0) ? s_axi_arready : (k == 1) ? s_axi_bvalid : s_axi_rvalid;
      @(posedge aclk);
   end
endtask
task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
   input logic [1:0] er = 2'b00);
   logic pa, pw, ta, tw;
   int n;
   bq.push_back(er);
   s_axi_awaddr <= a;
   s_axi_wdata <= d;
   s_axi_awvalid <= 1'b1;
   s_axi_wvalid <= 1'b1;
   pa = 1'b1;
   pw = 1'b1;
   for (n = 0; pa || pw; n++) begin
      if (n > 99) hang();
      @(negedge aclk);
      ta = pa && s_axi_awready;
      tw = pw && s_axi_wready;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      pa = pa && !ta;
      pw = pw && !tw;
   end
   // late bready keeps the response waiting one cycle
   @(posedge aclk);
   s_axi_bready <= 1'b1;
   wt(1);
   s_axi_bready <= 1'b0;
endtask
task automatic axi_rd(input logic [11:0] a, input logic [31:0] ed,
   input logic [1:0] er = 2'b00);
   rq.push_back({er, ed});
   s_axi_araddr <= a;
   s_axi_arvalid <= 1'b1;
   wt(0);
   s_axi_arvalid <= 1'b0;
   @(posedge aclk);
   s_axi_rready <= 1'b1;
   wt(2);
   s_axi_rready <= 1'b0;
endtask
task automatic cfg(input int e, input logic [31:0] c, p, d);
   logic [31:0] w [6];
   int i;
   ctl[e] = c;
   idv[e] = rnd() & (c[1] ? 32'h1FFFFFFF : 32'h000007FF);
   lo[e] = rnd();
   hi[e] = rnd();
   w = '{c, p, d, idv[e], lo[e], hi[e]};
   for (i = 0; i < 6; i++)
      axi_wr(`PCTS_ENT_BASE + 12'(e * 32 + i * 4), w[i]);
endtask

////////////////////////////////////////////////////////////////////////////
always @(posedge aclk) begin
   if (s_axi_bvalid && s_axi_bready)
      chk("bresp", s_axi_bresp, bq.pop_front());
   if (s_axi_rvalid && s_axi_rready)
      chk("rdata", {s_axi_rresp, s_axi_rdata}, rq.pop_front());
   if (tx_valid && tx_ready) begin
      if (eq.size() == 0) chk("extra frame", 1, 0);
      fe = eq.pop_front();
      chk("tick", (cyc - t0 + 8) / TK, tq.pop_front());
      chk("long", long_identifier_flag, ctl[fe][1]);
      chk("ident", frame_identifier, idv[fe]);
      chk("length", tx_length, ctl[fe][11:8]);
      chk("payload", payload_bytes, {hi[fe], lo[fe]});
      chk("copies", {copy_to_host, copy_to_logger}, ctl[fe][5:4]);
   end
end
initial begin
   repeat (TK * 8 + 5000) @(posedge aclk);
   hang();
end
initial begin
   logic [31:0] ld;
   repeat (8) @(posedge aclk);
   aresetn <= 1'b1;
   @(posedge aclk);
   axi_rd(`PCTS_REG_STATUS, 32'h00000000);
   axi_rd(12'h0F0, 32'h00000000, `PCTS_RESP_SLVERR);
   axi_wr(12'h0F4, 32'h00000001, `PCTS_RESP_SLVERR);
   ld = rnd() | 32'h00000001;
   axi_wr(`PCTS_REG_TIME_LOAD, ld);
   axi_wr(`PCTS_REG_START, 32'h00000001);
   axi_rd(`PCTS_REG_RTC, ld);
   chk("rtc port", rtc_seconds_r, ld);
   axi_wr(`PCTS_REG_TIME_ADJ, 32'hFFFFFFFB);
   axi_rd(`PCTS_REG_RTC, ld - 32'h00000005);
   axi_wr(`PCTS_REG_TIME_ADJ, 32'h0001FA41);
   axi_rd(`PCTS_REG_RTC, ld - 32'h00000005);
   axi_wr(`PCTS_REG_TIME_ADJ, 32'hFFFE05C0);
   ld = ld - 32'h00000005 - 32'h0001FA40;
   axi_rd(`PCTS_REG_RTC, ld);
   axi_wr(`PCTS_REG_START, 32'h00000000);
   axi_wr(`PCTS_REG_TIME_LOAD, 32'h00000000);
   axi_wr(`PCTS_REG_START, 32'h00000001);
   axi_rd(`PCTS_REG_RTC, ld);
   s_axi_wstrb <= 4'h3;
   axi_wr(`PCTS_REG_TIME_LOAD, 32'hFFFFFFFF);
   s_axi_wstrb <= 4'hF;
   axi_rd(`PCTS_REG_TIME_LOAD, 32'h0000FFFF);
   axi_wr(`PCTS_REG_TIME_LOAD, 32'h00000000);
   axi_wr(`PCTS_REG_START, 32'h00000000);
   cfg(0, 32'h00000101, 32'h00000028, 32'h0000000A);
   cfg(1, 32'h00000833, 32'h00000028, 32'h0000001E);
   cfg(2, 32'h00000230, 32'h0000000A, 32'h00000000);
   cfg(3, 32'h00000011, 32'h00000000, 32'h00000014);
   cfg(19, 32'h00000521, 32'h00000000, 32'h00000000);
   foreach (xe[k]) begin
      eq.push_back(xe[k]);
      tq.push_back(xt[k]);
   end
   axi_wr(`PCTS_REG_START, 32'h00000001);
   t0 = cyc;
   repeat (TK * 5 + TK / 2) @(posedge aclk);
   chk("frames left", eq.size(), 0);
   axi_wr(`PCTS_REG_START, 32'h00000000);
   end_of_test();
end
endmodule // tb_top
`default_nettype wire
